// ==== src/fifc_config_bank.sv ====
// Queue, interrupt-pin map and range/rate/filter configuration bank
//
// Function
// - The two-bit queue mode selects off, keep-oldest, streaming or triggered capture.
// - With the temperature-store bit set, a temperature word follows each x, y, z set.
// - Queue control bit 3 is the top bit of the nine-bit sample count, 0 to 511.
// - The nine-bit sample count sets the queue level at which the watermark rises.
// - The low byte of the sample count resets to 0x80 so no watermark follows reset.
// - Each interrupt pin is the OR of all status conditions enabled in its map bits 6:0.
// - Map bit 7 picks pin polarity: 0 active high, 1 active low.
// - With nothing mapped, the pin driver is off and the pin floats on its keeper.
// - Map bits: 6 awake, 5 stillness, 4 motion, 3 overrun, 2 watermark, 1 data, 0 new sample.
// - The second pin map has the same layout and acts on the second pin alone.
// - Every source stays readable as its own status flag whatever the mapping.
// - The bandwidth bit picks a quarter (1) or half (0) of the rate; it resets to 1.
// - With the external trigger bit set, conversions are timed by the second pin as input.
// - The rate field picks 12.5, 25, 50, 100, 200 Hz, and 400 Hz for 101 to 111; reset 011.
// - The range, rate and filter register resets to 0x13.
`timescale 1ns/1ns
module fifc_config_bank #(
   parameter int RATE_BASE_CYCLES = fifc_pkg::FASTEST_PERIOD_CYCLES,
   parameter int QUEUE_DEPTH = fifc_pkg::QUEUE_DEPTH_DEF
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic srcAwake,
   input wire logic srcStillness,
   input wire logic srcMotion,
   input wire logic srcOverrun,
   input wire logic srcNewSample,
   input wire logic [9:0] queueLevel,
   output logic irqPinOneOut,
   output logic irqPinOneOeN,
   input wire logic irqPinTwoIn,
   output logic irqPinTwoOut,
   output logic irqPinTwoOeN,
   output fifc_pkg::fifc_cfg_s cfg,
   output logic conversionStrobe,
   output logic queuePush,
   output logic [1:0] queueWordSel
);
   logic [7:0] queueCtrl_reg, queueCtrl_next;
   logic [7:0] sampleCnt_reg, sampleCnt_next;
   logic [7:0] pinOneMap_reg, pinOneMap_next;
   logic [7:0] pinTwoMap_reg, pinTwoMap_next;
   logic [7:0] rrfCtrl_reg, rrfCtrl_next;
   fifc_pkg::fifc_cfg_s cfg_reg, cfg_next;
   logic [7:0] rdData_reg, rdData_next;
   logic rdValid_reg, rdValid_next;
   logic pinOneOut_reg, pinOneOut_next, pinOneOeN_reg, pinOneOeN_next;
   logic pinTwoOut_reg, pinTwoOut_next, pinTwoOeN_reg, pinTwoOeN_next;
   fifc_pkg::fifc_push_e push_reg, push_next;
   logic qPush_reg, qPush_next;
   logic [1:0] wordSel_reg, wordSel_next;
   fifc_pkg::fifc_irq_src_s flags;
   logic [8:0] sampleCount;
   logic watermark, startOk;
   logic [2:0] rateSel, setWords;
   logic strobe;

   assign sampleCount = {queueCtrl_reg[fifc_pkg::SAMPLE_MSB_BIT], sampleCnt_reg};
   assign watermark = {1'b0, sampleCount} <= queueLevel;
   assign flags = {srcAwake, srcStillness, srcMotion, srcOverrun,
                   watermark, queueLevel != 10'h000, srcNewSample};

   // Register writes and derived configuration
   always_comb begin
      queueCtrl_next = queueCtrl_reg;
      sampleCnt_next = sampleCnt_reg;
      pinOneMap_next = pinOneMap_reg;
      pinTwoMap_next = pinTwoMap_reg;
      rrfCtrl_next = rrfCtrl_reg;
      if (regWrEn) begin
         case (regAddr)
            fifc_pkg::QUEUE_CTRL_OFS: queueCtrl_next = regWrData;
            fifc_pkg::SAMPLE_CNT_OFS: sampleCnt_next = regWrData;
            fifc_pkg::PIN_ONE_MAP_OFS: pinOneMap_next = regWrData;
            fifc_pkg::PIN_TWO_MAP_OFS: pinTwoMap_next = regWrData;
            fifc_pkg::RRF_CTRL_OFS: rrfCtrl_next = regWrData;
            default: ;
         endcase
      end
      rateSel = rrfCtrl_next[fifc_pkg::RATE_LSB +: 3];
      cfg_next.queueMode = fifc_pkg::fifc_queue_mode_e'(
         queueCtrl_next[fifc_pkg::MODE_LSB +: 2]);
      cfg_next.tempStore = queueCtrl_next[fifc_pkg::TEMP_STORE_BIT];
      cfg_next.sampleCount = {queueCtrl_next[fifc_pkg::SAMPLE_MSB_BIT], sampleCnt_next};
      if (rrfCtrl_next[fifc_pkg::RANGE_LSB + 1]) begin
         cfg_next.fullScaleG = fifc_pkg::SCALE_8G;
      end else if (rrfCtrl_next[fifc_pkg::RANGE_LSB]) begin
         cfg_next.fullScaleG = fifc_pkg::SCALE_4G;
      end else begin
         cfg_next.fullScaleG = fifc_pkg::SCALE_2G;
      end
      cfg_next.bwDivisor = rrfCtrl_next[fifc_pkg::QUARTER_BW_BIT] ?
         fifc_pkg::BW_DIV_QUARTER : fifc_pkg::BW_DIV_HALF;
      cfg_next.extTrigger = rrfCtrl_next[fifc_pkg::EXT_TRIG_BIT];
      cfg_next.rateCode = (rateSel > fifc_pkg::RATE_MAX) ? fifc_pkg::RATE_MAX : rateSel;
   end

   // Reads: unmapped offsets return zero
   always_comb begin
      rdValid_next = regRdEn;
      rdData_next = rdData_reg;
      if (regRdEn) begin
         case (regAddr)
            fifc_pkg::QUEUE_CTRL_OFS: rdData_next = queueCtrl_reg;
            fifc_pkg::SAMPLE_CNT_OFS: rdData_next = sampleCnt_reg;
            fifc_pkg::PIN_ONE_MAP_OFS: rdData_next = pinOneMap_reg;
            fifc_pkg::PIN_TWO_MAP_OFS: rdData_next = pinTwoMap_reg;
            fifc_pkg::RRF_CTRL_OFS: rdData_next = rrfCtrl_reg;
            fifc_pkg::STATUS_OFS: rdData_next = {1'b0, flags};
            default: rdData_next = 8'h00;
         endcase
      end
   end

   // Pin drivers; disabled drivers park the data low
   always_comb begin
      pinOneOut_next = 1'b0;
      pinOneOeN_next = 1'b1;
      pinTwoOut_next = 1'b0;
      pinTwoOeN_next = 1'b1;
      if (|pinOneMap_reg[6:0]) begin
         pinOneOeN_next = 1'b0;
         pinOneOut_next = (|(pinOneMap_reg[6:0] & flags))
                          ^ pinOneMap_reg[fifc_pkg::POLARITY_BIT];
      end
      // Pin two turns input while the external trigger owns it
      if ((|pinTwoMap_reg[6:0]) && !cfg_reg.extTrigger) begin
         pinTwoOeN_next = 1'b0;
         pinTwoOut_next = (|(pinTwoMap_reg[6:0] & flags))
                          ^ pinTwoMap_reg[fifc_pkg::POLARITY_BIT];
      end
   end

   // Queue push sequencer, one word per cycle after each conversion
   assign setWords = cfg_reg.tempStore ? 3'h4 : 3'h3;
   // Keep-oldest stops once a whole set no longer fits
   assign startOk = (cfg_reg.queueMode != fifc_pkg::QM_OFF) &&
      !(cfg_reg.queueMode == fifc_pkg::QM_OLDEST &&
        (11'(queueLevel) + 11'(setWords)) > 11'(QUEUE_DEPTH));

   always_comb begin
      push_next = push_reg;
      unique case (push_reg)
         fifc_pkg::PS_IDLE: begin
            if (strobe && startOk) begin
               push_next = fifc_pkg::PS_X;
            end
         end
         fifc_pkg::PS_X: push_next = fifc_pkg::PS_Y;
         fifc_pkg::PS_Y: push_next = fifc_pkg::PS_Z;
         fifc_pkg::PS_Z: push_next = cfg_reg.tempStore ? fifc_pkg::PS_T : fifc_pkg::PS_IDLE;
         fifc_pkg::PS_T: push_next = fifc_pkg::PS_IDLE;
         default: push_next = fifc_pkg::PS_IDLE;
      endcase
      qPush_next = push_next != fifc_pkg::PS_IDLE;
      unique case (push_next)
         fifc_pkg::PS_Y: wordSel_next = fifc_pkg::WORD_Y;
         fifc_pkg::PS_Z: wordSel_next = fifc_pkg::WORD_Z;
         fifc_pkg::PS_T: wordSel_next = fifc_pkg::WORD_T;
         default: wordSel_next = fifc_pkg::WORD_X;
      endcase
   end

   // Reset acts even while the clock enable is low
   always_ff @(posedge mclk) begin
      if (srst) begin
         queueCtrl_reg <= fifc_pkg::QUEUE_CTRL_RST;
         sampleCnt_reg <= fifc_pkg::SAMPLE_CNT_RST;
         pinOneMap_reg <= fifc_pkg::MAP_RST;
         pinTwoMap_reg <= fifc_pkg::MAP_RST;
         rrfCtrl_reg <= fifc_pkg::RRF_CTRL_RST;
         cfg_reg <= {fifc_pkg::QM_OFF, 1'b0, 9'h080, fifc_pkg::SCALE_2G,
                     fifc_pkg::BW_DIV_QUARTER, 1'b0, 3'h3};
         rdData_reg <= 8'h00;
         rdValid_reg <= 1'b0;
         pinOneOut_reg <= 1'b0;
         pinOneOeN_reg <= 1'b1;
         pinTwoOut_reg <= 1'b0;
         pinTwoOeN_reg <= 1'b1;
         push_reg <= fifc_pkg::PS_IDLE;
         qPush_reg <= 1'b0;
         wordSel_reg <= fifc_pkg::WORD_X;
      end else if (ce) begin
         queueCtrl_reg <= queueCtrl_next;
         sampleCnt_reg <= sampleCnt_next;
         pinOneMap_reg <= pinOneMap_next;
         pinTwoMap_reg <= pinTwoMap_next;
         rrfCtrl_reg <= rrfCtrl_next;
         cfg_reg <= cfg_next;
         rdData_reg <= rdData_next;
         rdValid_reg <= rdValid_next;
         pinOneOut_reg <= pinOneOut_next;
         pinOneOeN_reg <= pinOneOeN_next;
         pinTwoOut_reg <= pinTwoOut_next;
         pinTwoOeN_reg <= pinTwoOeN_next;
         push_reg <= push_next;
         qPush_reg <= qPush_next;
         wordSel_reg <= wordSel_next;
      end
   end

   fifc_sample_timer #(
      .BASE_CYCLES(RATE_BASE_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .rateCode(cfg_reg.rateCode),
      .extTrigger(cfg_reg.extTrigger),
      .trigPinIn(irqPinTwoIn),
      .strobe(strobe)
   );

   assign regRdData = rdData_reg;
   assign regRdValid = rdValid_reg;
   assign irqPinOneOut = pinOneOut_reg;
   assign irqPinOneOeN = pinOneOeN_reg;
   assign irqPinTwoOut = pinTwoOut_reg;
   assign irqPinTwoOeN = pinTwoOeN_reg;
   assign cfg = cfg_reg;
   assign conversionStrobe = strobe;
   assign queuePush = qPush_reg;
   assign queueWordSel = wordSel_reg;

   property p_off_no_push;
      @(posedge mclk) disable iff (srst)
      ce && cfg_reg.queueMode == fifc_pkg::QM_OFF && push_reg == fifc_pkg::PS_IDLE
      |=> !queuePush;
   endproperty
   a_off_no_push: assert property (p_off_no_push) else $error("push while queue off");

   property p_temp_word;
      @(posedge mclk) disable iff (srst)
      ce && push_reg == fifc_pkg::PS_Z && cfg_reg.tempStore
      |=> queuePush && queueWordSel == fifc_pkg::WORD_T;
   endproperty
   a_temp_word: assert property (p_temp_word) else $error("temperature word missing");

   property p_count_msb;
      @(posedge mclk) disable iff (srst)
      $rose(rdValid_reg) && $past(regAddr) == fifc_pkg::QUEUE_CTRL_OFS && !$past(regWrEn)
      |-> regRdData[fifc_pkg::SAMPLE_MSB_BIT] == cfg.sampleCount[8];
   endproperty
   a_count_msb: assert property (p_count_msb) else $error("count msb mismatch");

   property p_watermark;
      @(posedge mclk) disable iff (srst)
      ce && regRdEn && regAddr == fifc_pkg::STATUS_OFS
      |=> regRdData[2] == ({1'b0, $past(cfg_reg.sampleCount)} <= $past(queueLevel));
   endproperty
   a_watermark: assert property (p_watermark) else $error("watermark flag wrong");

   property p_reset_vals;
      @(posedge mclk) disable iff (srst)
      $fell(srst) |-> sampleCnt_reg == 8'h80 && rrfCtrl_reg == 8'h13
         && cfg.rateCode == 3'h3 && cfg.bwDivisor == 3'h4;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

   property p_pin_one;
      @(posedge mclk) disable iff (srst)
      ce && (|pinOneMap_reg[6:0])
      |=> !irqPinOneOeN && irqPinOneOut ==
         ((|($past(pinOneMap_reg[6:0]) & $past(flags))) ^ $past(pinOneMap_reg[7]));
   endproperty
   a_pin_one: assert property (p_pin_one) else $error("pin one level wrong");

   property p_pin_off;
      @(posedge mclk) disable iff (srst)
      ce && pinOneMap_reg[6:0] == 7'h00 |=> irqPinOneOeN;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("unmapped pin driven");

   property p_pin_two;
      @(posedge mclk) disable iff (srst)
      ce && (|pinTwoMap_reg[6:0]) && !cfg_reg.extTrigger
      |=> !irqPinTwoOeN && irqPinTwoOut ==
         ((|($past(pinTwoMap_reg[6:0]) & $past(flags))) ^ $past(pinTwoMap_reg[7]));
   endproperty
   a_pin_two: assert property (p_pin_two) else $error("pin two level wrong");

   property p_ext_release;
      @(posedge mclk) disable iff (srst)
      ce && cfg_reg.extTrigger |=> irqPinTwoOeN;
   endproperty
   a_ext_release: assert property (p_ext_release) else $error("trigger pin driven");

   property p_rate_clamp;
      @(posedge mclk) disable iff (srst)
      cfg.rateCode == ((rrfCtrl_reg[2:0] > 3'h5) ? 3'h5 : rrfCtrl_reg[2:0]);
   endproperty
   a_rate_clamp: assert property (p_rate_clamp) else $error("rate code wrong");

   property p_range;
      @(posedge mclk) disable iff (srst)
      cfg.fullScaleG == (rrfCtrl_reg[7] ? 4'h8 : (rrfCtrl_reg[6] ? 4'h4 : 4'h2));
   endproperty
   a_range: assert property (p_range) else $error("full scale wrong");

   c_temp_set: cover property (@(posedge mclk) disable iff (srst)
      queuePush && queueWordSel == fifc_pkg::WORD_T);
   c_pin_low: cover property (@(posedge mclk) disable iff (srst)
      !irqPinOneOeN && pinOneMap_reg[7] && !irqPinOneOut);
   c_ext_strobe: cover property (@(posedge mclk) disable iff (srst)
      cfg.extTrigger && conversionStrobe);
   c_oldest_full: cover property (@(posedge mclk) disable iff (srst)
      strobe && cfg_reg.queueMode == fifc_pkg::QM_OLDEST && !startOk);
endmodule // fifc_config_bank

// ==== src/fifc_pkg.sv ====
// Shared constants and types for the queue, interrupt-pin and filter config bank
package fifc_pkg;
   // Register offsets
   localparam logic [7:0] QUEUE_CTRL_OFS = 8'h28;
   localparam logic [7:0] SAMPLE_CNT_OFS = 8'h29;
   localparam logic [7:0] PIN_ONE_MAP_OFS = 8'h2a;
   localparam logic [7:0] PIN_TWO_MAP_OFS = 8'h2b;
   localparam logic [7:0] RRF_CTRL_OFS = 8'h2c;
   localparam logic [7:0] STATUS_OFS = 8'h30;
   // Reset values
   localparam logic [7:0] QUEUE_CTRL_RST = 8'h00;
   localparam logic [7:0] SAMPLE_CNT_RST = 8'h80;
   localparam logic [7:0] MAP_RST = 8'h00;
   localparam logic [7:0] RRF_CTRL_RST = 8'h13;
   // Field positions
   localparam int SAMPLE_MSB_BIT = 3;
   localparam int TEMP_STORE_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam int POLARITY_BIT = 7;
   localparam int RANGE_LSB = 6;
   localparam int QUARTER_BW_BIT = 4;
   localparam int EXT_TRIG_BIT = 3;
   localparam int RATE_LSB = 0;
   // Rate, range and bandwidth encodings
   localparam logic [2:0] RATE_MAX = 3'h5;
   localparam logic [3:0] SCALE_2G = 4'h2;
   localparam logic [3:0] SCALE_4G = 4'h4;
   localparam logic [3:0] SCALE_8G = 4'h8;
   localparam logic [2:0] BW_DIV_HALF = 3'h2;
   localparam logic [2:0] BW_DIV_QUARTER = 3'h4;
   // Timing, queue depth and push word selects
   localparam int CLK_HZ = 100_000_000;
   localparam int FASTEST_RATE_HZ = 400;
   localparam int FASTEST_PERIOD_CYCLES = CLK_HZ / FASTEST_RATE_HZ;
   localparam int QUEUE_DEPTH_DEF = 512;
   localparam logic [1:0] WORD_X = 2'h0;
   localparam logic [1:0] WORD_Y = 2'h1;
   localparam logic [1:0] WORD_Z = 2'h2;
   localparam logic [1:0] WORD_T = 2'h3;

   typedef enum logic [1:0] {
      QM_OFF = 2'h0,
      QM_OLDEST = 2'h1,
      QM_STREAM = 2'h2,
      QM_TRIGGERED = 2'h3
   } fifc_queue_mode_e;

   typedef enum logic [4:0] {
      PS_IDLE = 5'h01,
      PS_X = 5'h02,
      PS_Y = 5'h04,
      PS_Z = 5'h08,
      PS_T = 5'h10
   } fifc_push_e;

   // Bit order matches the pin map registers
   typedef struct packed {
      logic awake;
      logic stillness;
      logic motion;
      logic overrun;
      logic watermark;
      logic hasData;
      logic newSample;
   } fifc_irq_src_s;

   typedef struct packed {
      fifc_queue_mode_e queueMode;
      logic tempStore;
      logic [8:0] sampleCount;
      logic [3:0] fullScaleG;
      logic [2:0] bwDivisor;
      logic extTrigger;
      logic [2:0] rateCode;
   } fifc_cfg_s;
endpackage

// ==== src/fifc_sample_timer.sv ====
// Conversion strobe from the internal rate timer or the external trigger pin
`timescale 1ns/1ns
module fifc_sample_timer #(
   parameter int BASE_CYCLES = fifc_pkg::FASTEST_PERIOD_CYCLES
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [2:0] rateCode,
   input wire logic extTrigger,
   input wire logic trigPinIn,
   output logic strobe
);
   localparam int CNT_W = $clog2(BASE_CYCLES * 32 + 1);

   logic sync1_reg, sync2_reg, sync3_reg;
   logic sync1_next, sync2_next, sync3_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next, period;
   logic strobe_reg, strobe_next;

   always_comb begin
      sync1_next = trigPinIn;
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
      // Slowest rate is 32 times the fastest period
      period = CNT_W'(BASE_CYCLES) << (fifc_pkg::RATE_MAX - rateCode);
      cnt_next = cnt_reg + CNT_W'(1);
      strobe_next = 1'b0;
      if (extTrigger) begin
         // Rising edge of the pin starts a conversion
         cnt_next = '0;
         strobe_next = sync2_reg & ~sync3_reg;
      end else if (cnt_reg >= period - CNT_W'(1)) begin
         // Compare with >= so a shorter period takes effect at once
         cnt_next = '0;
         strobe_next = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         cnt_reg <= '0;
         strobe_reg <= 1'b0;
      end else if (ce) begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
         cnt_reg <= cnt_next;
         strobe_reg <= strobe_next;
      end
   end

   assign strobe = strobe_reg;
endmodule // fifc_sample_timer

// ==== verification/fifc_host_model.sv ====
// Host model: register port tasks and the shared second interrupt pin
`timescale 1ns/1ns
module fifc_host_model (
   input wire logic mclk,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic irqPinTwoOut,
   input wire logic irqPinTwoOeN,
   output logic pinLevel
);
   logic extEn = 1'b0;
   logic extLvl = 1'b0;
   logic keepLvl = 1'b0;
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // Keeper holds the last level while nobody drives
   always @* begin
      if (!irqPinTwoOeN) keepLvl = irqPinTwoOut;
      else if (extEn) keepLvl = extLvl;
   end
   assign pinLevel = keepLvl;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge mclk);
      #1;
      regWrEn = 1'b0;
      // Released lines show the inverse so stale values cannot pass
      regAddr = ~a;
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge mclk);
      #1;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge mclk);
      #1;
      regRdEn = 1'b0;
      regAddr = ~a;
      ok = regRdValid;
      d = regRdData;
   endtask
   // Trigger pulses at the link rate; the line stands still between trains
   task automatic pulses(input int n);
      extEn = 1'b1;
      repeat (n) begin
         #63;
         extLvl = 1'b1;
         #62;
         extLvl = 1'b0;
      end
      extEn = 1'b0;
   endtask
endmodule // fifc_host_model

// ==== verification/tb_fifc_config_bank.sv ====
// Self-checking bench for the queue, pin map and filter config bank
`timescale 1ns/1ns
module tb_fifc_config_bank;
   localparam int BASE = 8;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic regWrEn;
   logic regRdEn;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [4:0] src = 5'h00;
   logic [9:0] queueLevel = 10'h000;
   logic irqPinOneOut;
   logic irqPinOneOeN;
   logic irqPinTwoIn;
   logic irqPinTwoOut;
   logic irqPinTwoOeN;
   fifc_pkg::fifc_cfg_s cfg;
   logic conversionStrobe;
   logic queuePush;
   logic [1:0] queueWordSel;
   logic [7:0] mreg [0:4];
   logic [7:0] rdv;
   logic [7:0] d;
   logic okv;
   int per, np, ns, e;
   int error_cnt = 0;
   int compares = 0;

   fifc_config_bank #(.RATE_BASE_CYCLES(BASE)) fifc_config_bank_i (
      .mclk(mclk), .srst(srst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
      .srcAwake(src[4]), .srcStillness(src[3]), .srcMotion(src[2]), .srcOverrun(src[1]),
      .srcNewSample(src[0]), .queueLevel(queueLevel), .irqPinOneOut(irqPinOneOut),
      .irqPinOneOeN(irqPinOneOeN), .irqPinTwoIn(irqPinTwoIn), .irqPinTwoOut(irqPinTwoOut),
      .irqPinTwoOeN(irqPinTwoOeN), .cfg(cfg), .conversionStrobe(conversionStrobe),
      .queuePush(queuePush), .queueWordSel(queueWordSel));
   fifc_host_model fifc_host_model_i (
      .mclk(mclk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
      .irqPinTwoOut(irqPinTwoOut), .irqPinTwoOeN(irqPinTwoOeN), .pinLevel(irqPinTwoIn));

   initial begin
      forever #5 mclk = ~mclk;
   end

   function automatic logic [7:0] stat();
      return {1'b0, src[4:1], queueLevel >= {1'b0, mreg[0][3], mreg[1]},
         queueLevel != 10'h000, src[0]};
   endfunction
   function automatic logic [1:0] exp_pin(input logic [7:0] m, input logic off);
      logic [7:0] s;
      s = stat();
      if (m[6:0] == 7'h00 || off) return 2'b10;
      return {1'b0, (|(m[6:0] & s[6:0])) ^ m[7]};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a >= 8'h28 && a <= 8'h2c) return mreg[a - 8'h28];
      if (a == 8'h30) return stat();
      return 8'h00;
   endfunction
   function automatic fifc_pkg::fifc_cfg_s mk_cfg();
      fifc_pkg::fifc_cfg_s c;
      c.queueMode = fifc_pkg::fifc_queue_mode_e'(mreg[0][1:0]);
      c.tempStore = mreg[0][2];
      c.sampleCount = {mreg[0][3], mreg[1]};
      c.fullScaleG = mreg[4][7] ? fifc_pkg::SCALE_8G :
         (mreg[4][6] ? fifc_pkg::SCALE_4G : fifc_pkg::SCALE_2G);
      c.bwDivisor = mreg[4][4] ? fifc_pkg::BW_DIV_QUARTER : fifc_pkg::BW_DIV_HALF;
      c.extTrigger = mreg[4][3];
      c.rateCode = (mreg[4][2:0] > fifc_pkg::RATE_MAX) ? fifc_pkg::RATE_MAX : mreg[4][2:0];
      return c;
   endfunction

   task automatic wrap_up();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic mism(input string m);
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) mism($sformatf("byte %h expected %h", got, exp));
   endtask
   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) mism($sformatf("pin oen/out %b expected %b", got, exp));
   endtask
   task automatic chk_cnt(input int got, input int exp);
      compares++;
      if (got != exp) mism($sformatf("count %0d expected %0d", got, exp));
   endtask
   task automatic chk_cfg(input fifc_pkg::fifc_cfg_s got, input fifc_pkg::fifc_cfg_s exp);
      compares++;
      if (got !== exp) mism($sformatf("cfg %h expected %h", got, exp));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      fifc_host_model_i.wr(a, v);
      if (a >= 8'h28 && a <= 8'h2c) mreg[a - 8'h28] = v;
   endtask
   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] x;
      x = exp_rd(a);
      fifc_host_model_i.rd(a, rdv, okv);
      chk_reg(rdv, x);
      chk_reg({7'h00, okv}, 8'h01);
   endtask
   // Interval between two strobes, checking word order of the burst in between
   task automatic meas(output int p, output int n);
      int k;
      k = 0;
      n = 0;
      while (conversionStrobe !== 1'b1 && k < 2000) begin
         cyc(1);
         k++;
      end
      cyc(1);
      p = 1;
      while (conversionStrobe !== 1'b1 && p < 2000) begin
         if (queuePush === 1'b1) chk_reg({6'h00, queueWordSel}, 8'(n));
         if (queuePush === 1'b1) n++;
         cyc(1);
         p++;
      end
      if (k >= 2000 || p >= 2000) mism("strobe wait timed out");
   endtask

   initial begin
      #900_000;
      mism("run limit reached");
      wrap_up();
   end

   initial begin
      void'($urandom(32'hdf94));
      mreg = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h13};
      repeat (5) @(posedge mclk);
      #1;
      srst = 1'b0;
      chk_cfg(cfg, mk_cfg());
      chk_pin({irqPinOneOeN, irqPinOneOut}, 2'b10);
      chk_pin({irqPinTwoOeN, irqPinTwoOut}, 2'b10);
      for (int a = 8'h28; a <= 8'h31; a++) rd_chk(8'(a));
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[2:0] = i[2:0];
         d[7:6] = i[1:0];
         d[4] = i[2];
         wr_reg(8'h2c, d);
         d = 8'($urandom);
         d[1:0] = i[1:0];
         wr_reg(8'h28, d);
         wr_reg(8'h29, 8'($urandom));
         chk_cfg(cfg, mk_cfg());
         rd_chk(8'h28);
         rd_chk(8'h2c);
      end
      $display("test config fields done");
      for (int i = 0; i < 24; i++) begin
         d = 8'($urandom);
         if (i % 4 == 0) d[6:0] = 7'h00;
         wr_reg(8'h2a, d);
         wr_reg(8'h2b, 8'($urandom));
         src = 5'($urandom);
         queueLevel = {1'b0, mreg[0][3], mreg[1]} + 10'($urandom_range(0, 2)) - 10'h001;
         cyc(3);
         chk_pin({irqPinOneOeN, irqPinOneOut}, exp_pin(mreg[2], 1'b0));
         chk_pin({irqPinTwoOeN, irqPinTwoOut}, exp_pin(mreg[3], mreg[4][3]));
         rd_chk(8'h30);
      end
      $display("test pin map done");
      wr_reg(8'h28, 8'h02);
      for (int r = 0; r < 8; r++) begin
         wr_reg(8'h2c, 8'(r));
         meas(per, np);
         meas(per, np);
         chk_cnt(per, BASE << (5 - (r > 5 ? 5 : r)));
         chk_cnt(np, 3);
      end
      $display("test rates done");
      // Level 509 makes a four-word set overflow the keep-oldest queue
      queueLevel = 10'd509;
      for (int m = 0; m < 8; m++) begin
         wr_reg(8'h28, 8'(m / 2) | (m % 2 == 1 ? 8'h04 : 8'h00));
         meas(per, np);
         meas(per, np);
         e = 3 + m % 2;
         if (m < 2 || (m / 2 == 1 && 509 + e > fifc_pkg::QUEUE_DEPTH_DEF)) e = 0;
         chk_cnt(np, e);
      end
      $display("test queue modes done");
      wr_reg(8'h28, 8'h06);
      wr_reg(8'h2c, 8'h18);
      wr_reg(8'h2b, 8'h01);
      cyc(8);
      chk_pin({irqPinTwoOeN, irqPinTwoOut}, 2'b10);
      ns = 0;
      np = 0;
      fork
         fifc_host_model_i.pulses(6);
         repeat (90) begin
            cyc(1);
            ns += int'(conversionStrobe === 1'b1);
            np += int'(queuePush === 1'b1);
         end
      join
      chk_cnt(ns, 6);
      chk_cnt(np, 24);
      $display("test external trigger done");
      // A write taken while the clock enable is low must be lost
      ce = 1'b0;
      fifc_host_model_i.wr(8'h2a, ~mreg[2]);
      ce = 1'b1;
      rd_chk(8'h2a);
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      mreg = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h13};
      chk_cfg(cfg, mk_cfg());
      chk_pin({irqPinTwoOeN, irqPinTwoOut}, 2'b10);
      rd_chk(8'h29);
      $display("test enable and reset done");
      wrap_up();
   end
endmodule // tb_fifc_config_bank
